//--- core/rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// system clock rate
`define RCS_CLK_MHZ            100
// reference cycles per primary clock period, and per bus sync period in agent mode
`define RCS_PRIM_DIV           4
`define RCS_AGENT_DIV          4
// durations in bus sync or primary clock periods
`define RCS_IN_ASSERT_TICKS    32
`define RCS_POR_ASSERT_TICKS   32
`define RCS_DRIVE_TICKS        512
`define RCS_SOFT_GAP_TICKS     16
`define RCS_STRAP_SETUP_TICKS  4
`define RCS_CFG_ON_TICKS       1
// strap outputs turn off combinationally, well inside this bound
`define RCS_CFG_OFF_NS         4
// lock budgets
`define RCS_PLL_LOCK_US        100
`define RCS_PLL_LOCK_CYC       (`RCS_PLL_LOCK_US * `RCS_CLK_MHZ)
`define RCS_DLL_MIN_CYC        7680
`define RCS_DLL_MAX_CYC        122880
// strap holding flops after reset
`define RCS_SRC_RESET          3'h0
`define RCS_DIV_RESET          1'h0

`endif

//--- core/rcs_pkg.sv
package rcs_pkg;

  typedef enum logic [2:0] {
    ST_POR,
    ST_DRIVE,
    ST_GAP,
    ST_PLL,
    ST_DLL,
    ST_RUN,
    ST_SOFT_ONLY
  } rcs_state_t;

  typedef struct packed {
    logic [2:0] reset_source;
    logic       clk_div;
  } rcs_straps_t;

endpackage

//--- core/rcs_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"

module rcs_tick_div #(
  parameter int unsigned PRIM_DIV  = `RCS_PRIM_DIV,
  parameter int unsigned AGENT_DIV = `RCS_AGENT_DIV
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  // mode
  input  wire logic agent_mode_in,
  input  wire logic div_sel_in,
  // ticks
  output logic      prim_tick_out,
  output logic      sync_tick_out
);

  logic [7:0] prim_cnt_reg;
  logic [7:0] agent_cnt_reg;
  logic       phase_reg;
  wire        prim_wrap  = (prim_cnt_reg == 8'(PRIM_DIV - 1));
  wire        agent_wrap = (agent_cnt_reg == 8'(AGENT_DIV - 1));
  wire        host_sync  = prim_wrap & (~div_sel_in | phase_reg);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prim_cnt_reg  <= 8'h00;
      agent_cnt_reg <= 8'h00;
      phase_reg     <= 1'b0;
    end else begin
      prim_cnt_reg  <= prim_wrap ? 8'h00 : prim_cnt_reg + 8'h01;
      agent_cnt_reg <= agent_wrap ? 8'h00 : agent_cnt_reg + 8'h01;
      if (prim_wrap) begin
        phase_reg <= ~phase_reg;
      end
    end
  end

  assign prim_tick_out = prim_wrap;
  // host mode: bus sync period follows the divide strap, one or two primary periods
  assign sync_tick_out = agent_mode_in ? agent_wrap : host_sync;

endmodule

`default_nettype wire

//--- core/rcs_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"

module rcs_seq #(
  parameter int unsigned PLL_LOCK_CYC = `RCS_PLL_LOCK_CYC,
  parameter int unsigned DLL_MIN_CYC  = `RCS_DLL_MIN_CYC,
  parameter int unsigned DLL_MAX_CYC  = `RCS_DLL_MAX_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  // power-on reset and mode
  input  wire logic                 power_on_reset_n_in,
  input  wire logic                 agent_mode_in,
  // open-drain reset lines
  input  wire logic                 hard_reset_line_n_in,
  output logic                      hard_reset_line_n_out,
  output logic                      hard_reset_line_oe_out,
  input  wire logic                 soft_reset_line_n_in,
  output logic                      soft_reset_line_n_out,
  output logic                      soft_reset_line_oe_out,
  // configuration straps
  input  wire logic [2:0]           reset_source_strap_in,
  input  wire logic                 input_clock_divide_strap_in,
  output rcs_pkg::rcs_straps_t      straps_out,
  output logic                      strap_oe_out,
  // lock indications
  input  wire logic                 pll_lock_in,
  input  wire logic                 dll_lock_in,
  // status
  output logic                      clocks_usable_out,
  output logic                      ready_out,
  output rcs_pkg::rcs_state_t       seq_state_out
);

  localparam int CNT_W = 17;
  localparam logic [CNT_W-1:0] PLL_C  = CNT_W'(PLL_LOCK_CYC);
  localparam logic [CNT_W-1:0] DMIN_C = CNT_W'(DLL_MIN_CYC);
  localparam logic [CNT_W-1:0] DMAX_C = CNT_W'(DLL_MAX_CYC);

  function automatic logic [5:0] sat_inc(input logic [5:0] v, input logic en);
    sat_inc = (en && v != 6'h3f) ? v + 6'h01 : v;
  endfunction

  logic                 rst_a_reg;
  logic                 rst_n;
  logic [1:0]           por_sync_reg;
  logic [1:0]           hard_sync_reg;
  logic [1:0]           soft_sync_reg;
  logic [5:0]           por_cnt_reg;
  logic [5:0]           hard_cnt_reg;
  logic [5:0]           soft_cnt_reg;
  logic                 por_armed_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;
  logic [1:0]           cfg_cnt_reg;
  rcs_pkg::rcs_state_t  state_reg;
  rcs_pkg::rcs_state_t  state_next;
  rcs_pkg::rcs_straps_t straps_reg;
  logic                 prim_tick;
  logic                 sync_tick;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_a_reg <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n     <= rst_a_reg;
    end
  end

  rcs_tick_div u_tick (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n),
    .agent_mode_in (agent_mode_in),
    .div_sel_in    (straps_reg.clk_div),
    .prim_tick_out (prim_tick),
    .sync_tick_out (sync_tick)
  );

  // synchronized levels; the first stage feeds only the second
  wire por_low  = ~por_sync_reg[1];
  wire hard_low = ~hard_sync_reg[1];
  wire soft_low = ~soft_sync_reg[1];

  // power-on reset is timed on the primary clock in host mode, bus sync in agent mode
  wire por_tick = agent_mode_in ? sync_tick : prim_tick;
  // the first tick after the fall may be partial, so qualifying needs one tick more
  wire por_qual = (por_cnt_reg > 6'(`RCS_POR_ASSERT_TICKS));
  wire in_ok    = (state_reg == rcs_pkg::ST_RUN) || (state_reg == rcs_pkg::ST_PLL) ||
                  (state_reg == rcs_pkg::ST_DLL);
  wire hard_hit = in_ok && (hard_cnt_reg > 6'(`RCS_IN_ASSERT_TICKS));
  wire soft_hit = in_ok && (soft_cnt_reg > 6'(`RCS_IN_ASSERT_TICKS));
  wire tick_st  = (state_reg == rcs_pkg::ST_DRIVE) || (state_reg == rcs_pkg::ST_GAP) ||
                  (state_reg == rcs_pkg::ST_SOFT_ONLY);
  wire hard_drv = (state_reg == rcs_pkg::ST_DRIVE);
  wire soft_drv = hard_drv || (state_reg == rcs_pkg::ST_GAP) ||
                  (state_reg == rcs_pkg::ST_SOFT_ONLY);
  wire capture  = (state_reg == rcs_pkg::ST_POR) && !por_low && por_armed_reg;
  // strap drive waits out any hard reset, driven or seen, and the power-on phase
  wire hard_busy = hard_drv || hard_low || (state_reg == rcs_pkg::ST_POR);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rcs_pkg::ST_POR: begin
        if (capture) begin
          state_next = rcs_pkg::ST_DRIVE;
        end
      end
      rcs_pkg::ST_DRIVE: begin
        // a tick may land on the entry cycle, so one extra tick keeps the hold full length
        if (cnt_reg > CNT_W'(`RCS_DRIVE_TICKS)) begin
          state_next = rcs_pkg::ST_GAP;
        end
      end
      rcs_pkg::ST_GAP: begin
        if (cnt_reg >= CNT_W'(`RCS_SOFT_GAP_TICKS)) begin
          state_next = rcs_pkg::ST_PLL;
        end
      end
      rcs_pkg::ST_PLL: begin
        if (pll_lock_in || cnt_reg >= PLL_C) begin
          state_next = rcs_pkg::ST_DLL;
        end
      end
      rcs_pkg::ST_DLL: begin
        if ((dll_lock_in && cnt_reg >= DMIN_C) || cnt_reg >= DMAX_C) begin
          state_next = rcs_pkg::ST_RUN;
        end
      end
      rcs_pkg::ST_SOFT_ONLY: begin
        if (cnt_reg > CNT_W'(`RCS_DRIVE_TICKS)) begin
          state_next = rcs_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = state_reg;
      end
    endcase
    if (hard_hit) begin
      state_next = rcs_pkg::ST_DRIVE;
    end else if (soft_hit) begin
      state_next = rcs_pkg::ST_SOFT_ONLY;
    end
    // a qualified power-on reset overrides everything
    if (por_low && por_qual) begin
      state_next = rcs_pkg::ST_POR;
    end
    if (state_next != state_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == '1) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + CNT_W'(tick_st ? sync_tick : 1'b1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      por_sync_reg  <= 2'h3;
      hard_sync_reg <= 2'h3;
      soft_sync_reg <= 2'h3;
      state_reg     <= rcs_pkg::ST_POR;
      cnt_reg       <= '0;
      por_armed_reg <= 1'b0;
    end else begin
      por_sync_reg  <= {por_sync_reg[0], power_on_reset_n_in};
      hard_sync_reg <= {hard_sync_reg[0], hard_reset_line_n_in};
      soft_sync_reg <= {soft_sync_reg[0], soft_reset_line_n_in};
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      por_armed_reg <= (por_armed_reg || (por_low && por_qual)) && !capture;
    end
  end

  // counters restart whenever the line is high, so short pulses never qualify
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg  <= 6'h00;
      hard_cnt_reg <= 6'h00;
      soft_cnt_reg <= 6'h00;
    end else begin
      por_cnt_reg  <= por_low ? sat_inc(por_cnt_reg, por_tick) : 6'h00;
      hard_cnt_reg <= (hard_low && in_ok) ? sat_inc(hard_cnt_reg, sync_tick) : 6'h00;
      soft_cnt_reg <= (soft_low && in_ok) ? sat_inc(soft_cnt_reg, sync_tick) : 6'h00;
    end
  end

  // straps latched on the release edge; setup is the board's job
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      straps_reg  <= {`RCS_SRC_RESET, `RCS_DIV_RESET};
      cfg_cnt_reg <= 2'h0;
    end else begin
      if (capture) begin
        straps_reg <= {reset_source_strap_in, input_clock_divide_strap_in};
      end
      if (hard_busy) begin
        cfg_cnt_reg <= 2'h0;
      end else if (sync_tick && cfg_cnt_reg != 2'h2) begin
        // the first tick may be partial, so a full period needs two
        cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
      end
    end
  end

  assign hard_reset_line_n_out  = 1'b0;
  assign soft_reset_line_n_out  = 1'b0;
  assign hard_reset_line_oe_out = hard_drv;
  assign soft_reset_line_oe_out = soft_drv;
  // raw pin in the path: the drive must drop in the same cycle, not after sync
  assign strap_oe_out = (cfg_cnt_reg == 2'h2) && hard_reset_line_n_in && !hard_drv;
  assign straps_out        = straps_reg;
  assign clocks_usable_out = (state_reg == rcs_pkg::ST_DLL) || (state_reg == rcs_pkg::ST_RUN);
  assign ready_out         = (state_reg == rcs_pkg::ST_RUN);
  assign seq_state_out     = state_reg;

  // helper counters for checks: reference cycles spent in each drive phase,
  // judged against the bus sync period so that the tick logic is not trusted
  wire  [3:0]  chk_period = agent_mode_in ? 4'(`RCS_AGENT_DIV) :
                            (straps_reg.clk_div ? 4'(2 * `RCS_PRIM_DIV) : 4'(`RCS_PRIM_DIV));
  logic [13:0] chk_hold_q;
  logic [13:0] chk_gap_q;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chk_hold_q <= 14'h0000;
      chk_gap_q  <= 14'h0000;
    end else begin
      chk_hold_q <= !hard_drv ? 14'h0000 : chk_hold_q + 14'(chk_hold_q != 14'h3fff);
      chk_gap_q  <= !(soft_drv && !hard_drv) ? 14'h0000 :
                    chk_gap_q + 14'(chk_gap_q != 14'h3fff);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  chk_lines_low_only: assert property (hard_reset_line_n_out == 1'b0 &&
    soft_reset_line_n_out == 1'b0 && (hard_reset_line_oe_out -> soft_reset_line_oe_out))
    else $error("reset lines not open drain low");
  chk_hard_hold_min: assert property ($fell(hard_reset_line_oe_out) &&
    state_reg != rcs_pkg::ST_POR |->
    $past(chk_hold_q) + 14'h0001 >= 14'(`RCS_DRIVE_TICKS) * 14'(chk_period))
    else $error("hard reset released early");
  chk_soft_gap_min: assert property ($fell(soft_reset_line_oe_out) &&
    state_reg != rcs_pkg::ST_POR |->
    $past(chk_gap_q) + 14'h0001 >= 14'(`RCS_SOFT_GAP_TICKS) * 14'(chk_period))
    else $error("soft reset released too soon after hard");
  chk_strap_off_now: assert property (!hard_reset_line_n_in |-> !strap_oe_out)
    else $error("strap drive during hard reset");
  chk_strap_on_late: assert property ($rose(strap_oe_out) |->
    !$past(hard_busy, 1) && !$past(hard_busy, 2) && !hard_drv)
    else $error("strap drive resumed too early");
  chk_input_qualify: assert property ((in_ok && state_next == rcs_pkg::ST_DRIVE) |->
    hard_cnt_reg > 6'(`RCS_IN_ASSERT_TICKS))
    else $error("reset flow started on short input pulse");
  chk_por_qualify: assert property ((state_reg != rcs_pkg::ST_POR) ##1
    (state_reg == rcs_pkg::ST_POR) |-> $past(por_cnt_reg) > 6'(`RCS_POR_ASSERT_TICKS))
    else $error("short power-on pulse accepted");
  chk_pll_budget: assert property ((state_reg == rcs_pkg::ST_PLL) |-> cnt_reg <= PLL_C)
    else $error("pll wait exceeded budget");
  chk_dll_window: assert property ((state_reg == rcs_pkg::ST_DLL &&
    state_next == rcs_pkg::ST_RUN && !hard_hit && !soft_hit) |-> cnt_reg >= DMIN_C)
    else $error("dll wait shorter than minimum");
  chk_strap_capture: assert property (capture && !(por_low && por_qual) |=>
    straps_out.reset_source == $past(reset_source_strap_in) &&
    straps_out.clk_div == $past(input_clock_divide_strap_in))
    else $error("straps not captured at release");

  cov_full_flow: cover property ((state_reg == rcs_pkg::ST_DLL) ##1
    (state_reg == rcs_pkg::ST_RUN));
  cov_soft_only: cover property (state_reg == rcs_pkg::ST_SOFT_ONLY);
  cov_hard_in: cover property (hard_hit && state_reg == rcs_pkg::ST_RUN);
  cov_dll_timeout: cover property (state_reg == rcs_pkg::ST_DLL && cnt_reg >= DMAX_C);

endmodule

`default_nettype wire

//--- dv/rcs_board.sv
`timescale 1ns/10ps
`default_nettype none

module rcs_board (
  // clock
  input  wire logic                 clk_in,
  // device drive enables
  input  wire logic                 hard_oe_in,
  input  wire logic                 soft_oe_in,
  input  wire logic                 strap_oe_in,
  input  wire rcs_pkg::rcs_straps_t dut_straps_in,
  // board side levels
  output logic                      por_n_out,
  output logic                      hard_n_out,
  output logic                      soft_n_out,
  output logic [2:0]                src_out,
  output logic                      div_out
);
  logic                 hard_pull;
  logic                 soft_pull;
  logic                 strap_drv;
  rcs_pkg::rcs_straps_t val;

  // lines float high unless someone pulls them low
  assign hard_n_out = ~(hard_oe_in | hard_pull);
  assign soft_n_out = ~(soft_oe_in | soft_pull);
  // undriven strap pins show the inverse so a stale value cannot pass
  assign {src_out, div_out} = strap_drv ? val : (strap_oe_in ? dut_straps_in : ~val);

  initial begin
    por_n_out = 1'b0;
    hard_pull = 1'b0;
    soft_pull = 1'b0;
    strap_drv = 1'b1;
    val       = '0;
  end

  // straps are applied on the same edge that power-on reset falls, long before release
  task automatic por(input rcs_pkg::rcs_straps_t s, input int n);
    @(negedge clk_in);
    strap_drv = 1'b1;
    val       = s;
    por_n_out = 1'b0;
    repeat (n) @(negedge clk_in);
    por_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    strap_drv = 1'b0;
  endtask

  task automatic pull(input logic hard, input int n);
    @(negedge clk_in);
    if (hard) hard_pull = 1'b1;
    else soft_pull = 1'b1;
    repeat (n) @(negedge clk_in);
    hard_pull = 1'b0;
    soft_pull = 1'b0;
  endtask
endmodule

`default_nettype wire

//--- dv/tb_rcs_seq.sv
`timescale 1ns/10ps
`default_nettype none

module tb_rcs_seq;
  localparam int PLL  = 50;
  localparam int DMIN = 20;
  localparam int DMAX = 60;

  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 agent = 1'b0;
  logic                 pll = 1'b0;
  logic                 dll = 1'b0;
  logic                 por_n, hard_n, soft_n, div, hard_no, hard_oe, soft_no, soft_oe;
  logic                 strap_oe, usable, ready;
  logic [2:0]           src;
  rcs_pkg::rcs_straps_t straps;
  rcs_pkg::rcs_state_t  st;
  int                   miscompares = 0;
  int                   compares = 0;

  always #5 clk = ~clk;

  rcs_seq #(.PLL_LOCK_CYC(PLL), .DLL_MIN_CYC(DMIN), .DLL_MAX_CYC(DMAX)) u_dut (
    .ref_clk_in(clk), .resetn_in(rstn), .power_on_reset_n_in(por_n), .agent_mode_in(agent),
    .hard_reset_line_n_in(hard_n), .hard_reset_line_n_out(hard_no),
    .hard_reset_line_oe_out(hard_oe), .soft_reset_line_n_in(soft_n),
    .soft_reset_line_n_out(soft_no), .soft_reset_line_oe_out(soft_oe),
    .reset_source_strap_in(src), .input_clock_divide_strap_in(div), .straps_out(straps),
    .strap_oe_out(strap_oe), .pll_lock_in(pll), .dll_lock_in(dll),
    .clocks_usable_out(usable), .ready_out(ready), .seq_state_out(st));

  rcs_board u_board (
    .clk_in(clk), .hard_oe_in(hard_oe), .soft_oe_in(soft_oe), .strap_oe_in(strap_oe),
    .dut_straps_in(straps), .por_n_out(por_n), .hard_n_out(hard_n), .soft_n_out(soft_n),
    .src_out(src), .div_out(div));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic check_rng(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
      miscompares++;
    end
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return hard_oe;
      1: return soft_oe;
      2: return st == rcs_pkg::ST_PLL;
      3: return st == rcs_pkg::ST_DLL;
      default: return ready;
    endcase
  endfunction

  task automatic dwell(input int sel, output int n);
    n = 0;
    while (sig(sel) === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_hi(input int sel, input int lim, input string what);
    int n;
    n = 0;
    while (sig(sel) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(what, 1, sig(sel));
  endtask

  // one full power-on flow; t is the bus sync period in clocks
  task automatic flow(input logic ag, dv, pe, de, input logic [2:0] s);
    int n;
    int t;
    t = (ag || !dv) ? 4 : 8;
    @(negedge clk);
    agent = ag;
    pll   = pe;
    dll   = de;
    u_board.por({s, dv}, 200);
    wait_hi(0, 40, "hard_oe");
    check("straps", {s, dv}, straps);
    check("strap_oe_drive", 0, strap_oe);
    check("hard_n_out", 0, hard_no);
    check("soft_n_out", 0, soft_no);
    dwell(0, n);
    check_rng("hard_len", 512 * t, 514 * t, n);
    check("soft_oe", 1, soft_oe);
    check("strap_oe_early", 0, strap_oe);
    dwell(1, n);
    check_rng("gap_len", 16 * t, 18 * t, n);
    check("strap_oe_back", 1, strap_oe);
    check("usable_pll", 0, usable);
    dwell(2, n);
    check_rng("pll_len", pe ? 0 : PLL - 1, pe ? 3 : PLL + 3, n);
    check("usable_dll", 1, usable);
    dwell(3, n);
    check_rng("dll_len", de ? DMIN - 1 : DMAX - 1, de ? DMIN + 3 : DMAX + 3, n);
    check("ready", 1, ready);
  endtask

  task automatic hard_in();
    int n;
    u_board.pull(1'b1, 20);
    repeat (100) @(negedge clk);
    check("short_hard", rcs_pkg::ST_RUN, st);
    check("strap_oe_resume", 1, strap_oe);
    fork
      u_board.pull(1'b1, 170);
    join_none
    repeat (2) @(negedge clk);
    check("strap_oe_ext", 0, strap_oe);
    wait_hi(0, 200, "hard_restart");
    dwell(0, n);
    check_rng("hard_in_len", 512 * 4, 514 * 4, n);
    wait_hi(4, 3000, "ready_again");
  endtask

  task automatic soft_in();
    int n;
    fork
      u_board.pull(1'b0, 170);
    join_none
    wait_hi(1, 200, "soft_restart");
    check("soft_state", rcs_pkg::ST_SOFT_ONLY, st);
    check("soft_no_hard", 0, hard_oe);
    dwell(1, n);
    check_rng("soft_in_len", 512 * 4, 514 * 4, n);
    wait_hi(4, 10, "ready_soft");
  endtask

  task automatic por_short();
    u_board.por(4'h9, 10);
    repeat (20) @(negedge clk);
    check("short_por", rcs_pkg::ST_RUN, st);
    check("short_por_straps", {3'h7, 1'b1}, straps);
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    flow(1'b0, 1'b0, 1'b1, 1'b1, 3'h5);
    flow(1'b0, 1'b1, 1'b0, 1'b0, 3'h2);
    flow(1'b1, 1'b1, 1'b1, 1'b0, 3'h7);
    hard_in();
    soft_in();
    por_short();
    test_done();
  end

  // whole plan runs well under 40000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule

`default_nettype wire
